/* File: rtl/oxygen_ctrl_map.vh */
`ifndef OXYGEN_CTRL_MAP_VH
`define OXYGEN_CTRL_MAP_VH

// Register byte offsets
`define OFS_MODE        6'h00
`define OFS_RANGE_LOW   6'h04
`define OFS_RANGE_MED   6'h08
`define OFS_RANGE_HIGH  6'h0C
`define OFS_HYST        6'h10
`define OFS_ALARM1      6'h14
`define OFS_ALARM2      6'h18
`define OFS_ACK         6'h1C
`define OFS_STATUS      6'h20
`define OFS_READOUT     6'h24

// Range mode codes
`define MODE_AUTO       2'h0
`define MODE_PIN_ONE    2'h1
`define MODE_PIN_TWO    2'h2
`define MODE_PIN_THREE  2'h3

// Active range codes
`define RNG_LOW         2'h0
`define RNG_MED         2'h1
`define RNG_HIGH        2'h2
`define RNG_CAL         2'h3

// Alarm config fields
`define AL_DIR_HIGH_BIT 16
`define AL_SUPPRESS_BIT 17
`define AL_FAILSAFE_BIT 18
`define AL_LATCH_BIT    19

// Status fields
`define ST_RANGE_LSB    0
`define ST_ALARM_LSB    2
`define ST_RELAY_LSB    4
`define ST_REJECT_BIT   6
`define ST_MODE_LSB     8

// Reset values and the fixed calibration full scale, concentration in units of 0.01 % oxygen
`define RST_RANGE_LOW   14'h0064
`define RST_RANGE_MED   14'h01F4
`define RST_RANGE_HIGH  14'h03E8
`define RST_HYST        14'h000A
`define RST_ALARM       20'h00000
`define CAL_FULL_SCALE  14'h09C4

`endif

/* File: rtl/oxygen_alarm_autorange_ctrl.v */
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "oxygen_ctrl_map.vh"

module oxygen_alarm_autorange_ctrl #(
  parameter CONC_W = 14,
  parameter DAC_W  = 12
) (
  // Clock and reset
  input  wire              clk_i,
  input  wire              rstn_i,
  // Register port
  input  wire [5:0]        addr_i,
  input  wire [31:0]       wdata_i,
  input  wire              wr_i,
  input  wire              rd_i,
  output reg  [31:0]       rdata_o,
  // Measurement path
  input  wire [CONC_W-1:0] conc_i,
  // Outputs
  output reg  [CONC_W-1:0] readout_o,
  output reg  [1:0]        range_o,
  output reg  [DAC_W-1:0]  conc_code_o,
  output reg  [DAC_W-1:0]  range_id_code_o,
  output reg  [1:0]        alarm_o,
  output reg  [1:0]        relay_o
);

  localparam [DAC_W-1:0] FULL_CODE = {DAC_W{1'b1}};

  reg  [1:0]        mode;
  reg  [CONC_W-1:0] fs_low;
  reg  [CONC_W-1:0] fs_med;
  reg  [CONC_W-1:0] fs_high;
  reg  [CONC_W-1:0] hyst;
  reg  [19:0]       al_cfg [0:1];
  reg               reject;

  wire [CONC_W-1:0] wval = wdata_i[CONC_W-1:0];
  wire              wr_low  = wr_i && (addr_i == `OFS_RANGE_LOW);
  wire              wr_med  = wr_i && (addr_i == `OFS_RANGE_MED);
  wire              wr_high = wr_i && (addr_i == `OFS_RANGE_HIGH);
  wire              ok_low  = (wval != {CONC_W{1'b0}}) && (wval < fs_med);
  wire              ok_med  = (wval > fs_low) && (wval < fs_high);
  wire              ok_high = wval > fs_med;
  wire              bad_wr  = (wr_low && !ok_low) || (wr_med && !ok_med) || (wr_high && !ok_high);
  wire              rd_stat = rd_i && (addr_i == `OFS_STATUS);
  wire [1:0]        ack     = (wr_i && (addr_i == `OFS_ACK)) ? wdata_i[1:0] : 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode      <= `MODE_AUTO;
      fs_low    <= `RST_RANGE_LOW;
      fs_med    <= `RST_RANGE_MED;
      fs_high   <= `RST_RANGE_HIGH;
      hyst      <= `RST_HYST;
      al_cfg[0] <= `RST_ALARM;
      al_cfg[1] <= `RST_ALARM;
      reject    <= 1'b0;
    end else begin
      if (wr_i && (addr_i == `OFS_MODE))
        mode <= wdata_i[1:0];
      // Out-of-order full scales are dropped and flagged
      if (wr_low && ok_low)
        fs_low <= wval;
      if (wr_med && ok_med)
        fs_med <= wval;
      if (wr_high && ok_high)
        fs_high <= wval;
      if (wr_i && (addr_i == `OFS_HYST))
        hyst <= wval;
      if (wr_i && (addr_i == `OFS_ALARM1))
        al_cfg[0] <= wdata_i[19:0];
      if (wr_i && (addr_i == `OFS_ALARM2))
        al_cfg[1] <= wdata_i[19:0];
      // Status read clears the flag, a new rejection in that cycle wins
      if (bad_wr)
        reject <= 1'b1;
      else if (rd_stat)
        reject <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm evaluation
  wire [1:0] next_alarm;
  wire [1:0] next_relay;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : alarm_ch
      wire [CONC_W-1:0] setpoint = al_cfg[g][CONC_W-1:0];
      wire              dir_high = al_cfg[g][`AL_DIR_HIGH_BIT];
      wire              suppress = al_cfg[g][`AL_SUPPRESS_BIT];
      wire              failsafe = al_cfg[g][`AL_FAILSAFE_BIT];
      wire              latch    = al_cfg[g][`AL_LATCH_BIT];
      wire              trip     = dir_high ? (conc_i > setpoint) : (conc_i < setpoint);
      // Suppress also wipes the latch, so leaving suppress starts clean
      // Latch off makes the alarm follow trip, so toggling latch clears it
      assign next_alarm[g] = suppress ? 1'b0 :
                             latch ? (trip | (alarm_o[g] & ~ack[g])) :
                             trip;
      assign next_relay[g] = failsafe ? ~next_alarm[g] : next_alarm[g];
    end
  endgenerate

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alarm_o <= 2'h0;
      relay_o <= 2'h0;
    end else begin
      alarm_o <= next_alarm;
      relay_o <= next_relay;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Range selection
  wire [CONC_W:0] conc_plus_hyst = {1'b0, conc_i} + {1'b0, hyst};
  reg  [1:0]      next_range;

  always @* begin
    next_range = range_o;
    if (mode != `MODE_AUTO) begin
      next_range = mode - 2'h1;
    end else begin
      case (range_o)
        `RNG_LOW: begin
          if (conc_i > fs_low)
            next_range = `RNG_MED;
        end
        `RNG_MED: begin
          if (conc_i > fs_med)
            next_range = `RNG_HIGH;
          else if (conc_plus_hyst < {1'b0, fs_low})
            next_range = `RNG_LOW;
        end
        `RNG_HIGH: begin
          // Calibration only above the highest range, never at its full scale (fs_high) itself
          if (conc_i > fs_high)
            next_range = `RNG_CAL;
          else if (conc_plus_hyst < {1'b0, fs_med})
            next_range = `RNG_MED;
        end
        `RNG_CAL: begin
          if (conc_i <= fs_high)
            next_range = `RNG_HIGH;
        end
        default: next_range = `RNG_HIGH;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DAC codes
  reg  [CONC_W-1:0]       cur_fs;
  always @* begin
    case (next_range)
      `RNG_LOW:  cur_fs = fs_low;
      `RNG_MED:  cur_fs = fs_med;
      `RNG_HIGH: cur_fs = fs_high;
      default:   cur_fs = `CAL_FULL_SCALE;
    endcase
  end

  // Divider is combinational; fine at 50 MHz for these widths, costs area
  wire [CONC_W-1:0]       clamped = (conc_i > cur_fs) ? cur_fs : conc_i;
  wire [CONC_W+DAC_W-1:0] scaled  = clamped * FULL_CODE;
  wire [CONC_W+DAC_W-1:0] quot    = scaled / cur_fs;
  wire [DAC_W-1:0]        rid     = (next_range == `RNG_CAL) ? FULL_CODE :
                                    {next_range + 2'h1, {(DAC_W-2){1'b0}}};

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      range_o         <= `RNG_LOW;
      conc_code_o     <= {DAC_W{1'b0}};
      range_id_code_o <= {2'h1, {(DAC_W-2){1'b0}}};
      readout_o       <= {CONC_W{1'b0}};
    end else begin
      range_o         <= next_range;
      conc_code_o     <= quot[DAC_W-1:0];
      range_id_code_o <= rid;
      readout_o       <= conc_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read
  reg [31:0] rmux;
  always @* begin
    rmux = 32'h00000000;
    case (addr_i)
      `OFS_MODE:       rmux[1:0] = mode;
      `OFS_RANGE_LOW:  rmux[CONC_W-1:0] = fs_low;
      `OFS_RANGE_MED:  rmux[CONC_W-1:0] = fs_med;
      `OFS_RANGE_HIGH: rmux[CONC_W-1:0] = fs_high;
      `OFS_HYST:       rmux[CONC_W-1:0] = hyst;
      `OFS_ALARM1:     rmux[19:0] = al_cfg[0];
      `OFS_ALARM2:     rmux[19:0] = al_cfg[1];
      `OFS_STATUS: begin
        rmux[`ST_RANGE_LSB+1:`ST_RANGE_LSB] = range_o;
        rmux[`ST_ALARM_LSB+1:`ST_ALARM_LSB] = alarm_o;
        rmux[`ST_RELAY_LSB+1:`ST_RELAY_LSB] = relay_o;
        rmux[`ST_REJECT_BIT]                = reject;
        rmux[`ST_MODE_LSB+1:`ST_MODE_LSB]   = mode;
      end
      `OFS_READOUT:    rmux[CONC_W-1:0] = readout_o;
      default:         rmux = 32'h00000000;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      rdata_o <= 32'h00000000;
    else if (rd_i)
      rdata_o <= rmux;
    else
      rdata_o <= 32'h00000000;
  end

endmodule // oxygen_alarm_autorange_ctrl
`default_nettype wire

/* File: dv/oxy_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "oxygen_ctrl_map.vh"
module oxy_ctrl_properties #(
  parameter CONC_W = 14,
  parameter DAC_W  = 12
) (
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              rstn_i,
  // Observed ports
  input wire logic              rd_i,
  input wire logic [31:0]       rdata_o,
  input wire logic [CONC_W-1:0] conc_i,
  input wire logic [CONC_W-1:0] readout_o,
  input wire logic [1:0]        range_o,
  input wire logic [DAC_W-1:0]  conc_code_o,
  input wire logic [DAC_W-1:0]  range_id_code_o,
  input wire logic [1:0]        alarm_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////////////////////
  // Linear checks assume the default full scales stay programmed
  a_readout_true: assert property (readout_o == $past(conc_i))
    else $error("readout not equal to concentration");
  a_range_id_map: assert property (range_id_code_o == (range_o == `RNG_LOW ? 12'h400 :
    range_o == `RNG_MED ? 12'h800 : range_o == `RNG_HIGH ? 12'hC00 : 12'hFFF)) else $error("range id code wrong");
  a_cal_clamp: assert property (range_o == `RNG_CAL && $past(conc_i) >= `CAL_FULL_SCALE |->
    conc_code_o == 12'hFFF) else $error("calibration code not clamped");
  a_low_linear: assert property (range_o == `RNG_LOW && $past(conc_i) <= 14'h0064 |->
    conc_code_o == 12'(({18'h0, $past(conc_i)} * 4095) / 100)) else $error("low range code wrong");
  a_med_linear: assert property (range_o == `RNG_MED && $past(conc_i) <= 14'h01F4 |->
    conc_code_o == 12'(({18'h0, $past(conc_i)} * 4095) / 500)) else $error("medium range code wrong");
  a_cal_entry: assert property (range_o == `RNG_CAL |-> $past(range_o) == `RNG_HIGH ||
    $past(range_o) == `RNG_CAL) else $error("calibration entered from below high");
  a_cal_leave: assert property ($past(range_o) == `RNG_CAL && range_o != `RNG_CAL |->
    range_o == `RNG_HIGH) else $error("calibration left to other than high");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its cycle");
  c_cal_range: cover property (range_o == `RNG_CAL);
  c_alarm_on: cover property (alarm_o != 2'h0);
  c_read_data: cover property (rd_i ##1 rdata_o != 32'h0);
endmodule // oxy_ctrl_properties
bind oxygen_alarm_autorange_ctrl oxy_ctrl_properties #(.CONC_W(CONC_W), .DAC_W(DAC_W)) i_props (
  .clk_i(clk_i), .rstn_i(rstn_i), .rd_i(rd_i), .rdata_o(rdata_o), .conc_i(conc_i), .readout_o(readout_o),
  .range_o(range_o), .conc_code_o(conc_code_o), .range_id_code_o(range_id_code_o), .alarm_o(alarm_o));
`default_nettype wire

/* File: dv/conc_source.sv */
`timescale 1ns/1ps
`default_nettype none
module conc_source #(
  parameter CONC_W = 14
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic [CONC_W-1:0] target_i,
  output var  logic [CONC_W-1:0] conc_o
);
  // Converter result lands one edge late, as a real sampled path would
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) conc_o <= '0;
    else conc_o <= target_i;
  end
endmodule // conc_source
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "oxygen_ctrl_map.vh"
module testbench;
  logic        clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, rd_d = 0;
  logic [5:0]  addr_i = 0;
  logic [31:0] wdata_i = 0, rdata_o;
  logic [13:0] target = 0, conc_i, readout_o, cur_c = 0, rc;
  logic [1:0]  range_o, alarm_o, relay_o, cur_r = 0, mode = 0;
  logic [11:0] conc_code_o, range_id_code_o;
  logic [43:0] exp_q[$], e;
  int          n_fail = 0, tests_run = 0, seed = 32'h97848a91;
  conc_source i_src (.clk_i(clk_i), .rstn_i(rstn_i), .target_i(target), .conc_o(conc_i));
  oxygen_alarm_autorange_ctrl i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conc_i(conc_i), .readout_o(readout_o), .range_o(range_o),
    .conc_code_o(conc_code_o), .range_id_code_o(range_id_code_o), .alarm_o(alarm_o), .relay_o(relay_o));
  initial forever #10 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] code(input logic [13:0] c, input logic [1:0] r);
    logic [31:0] fs;
    fs = r == `RNG_LOW ? 100 : r == `RNG_MED ? 500 : r == `RNG_HIGH ? 1000 : 2500;
    return 12'(((c > fs ? fs : {18'h0, c}) * 4095) / fs);
  endfunction
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] x);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back({code(cur_c, cur_r), x});
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  // Settle four edges: one of path latency plus up to three range steps
  task automatic st(input logic [13:0] c, input logic [1:0] r, al, rl, input logic rj);
    target <= c;
    cur_c = c;
    cur_r = r;
    repeat (4) @(posedge clk_i);
    rd(`OFS_STATUS, {22'h0, mode, 1'b0, rj, rl, al, r});
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) rd_d <= rd_i;
  always @(negedge clk_i) begin
    if (rd_d && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      tests_run += 2;
      if (rdata_o !== e[31:0]) begin
        n_fail++;
        $display("CHECK FAILED rdata exp %h got %h", e[31:0], rdata_o);
      end
      if (conc_code_o !== e[43:32]) begin
        n_fail++;
        $display("CHECK FAILED conc_code exp %h got %h", e[43:32], conc_code_o);
      end
    end
  end
  initial begin
    #80000;
    n_fail++;
    finish_test;
  end
  initial begin
    logic [13:0] cs[10];
    logic [1:0]  rs[10];
    cs = '{50, 150, 600, 1200, 3000, 900, 495, 480, 95, 80};
    rs = '{0, 1, 2, 3, 3, 2, 2, 1, 1, 0};
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(`OFS_RANGE_LOW, 32'h64);
    rd(`OFS_RANGE_MED, 32'h1F4);
    rd(`OFS_RANGE_HIGH, 32'h3E8);
    rd(6'h3C, 32'h0);
    st(0, `RNG_LOW, 0, 0, 0);
    for (int i = 0; i < 10; i++) begin
      st(cs[i], rs[i], 0, 0, 0);
      rd(`OFS_READOUT, {18'h0, cs[i]});
    end
    wr(`OFS_MODE, 32'h2);
    mode = 2;
    for (int i = 0; i < 6; i++) begin
      rc = 14'($unsigned($random(seed)) % 2001);
      st(rc, `RNG_MED, 0, 0, 0);
    end
    wr(`OFS_RANGE_HIGH, 32'h32);
    st(100, `RNG_MED, 0, 0, 1);
    rd(`OFS_RANGE_HIGH, 32'h3E8);
    wr(`OFS_ALARM1, 32'h000D012C);
    wr(`OFS_ALARM2, 32'h000000C8);
    st(250, `RNG_MED, 2'b00, 2'b01, 0);
    st(400, `RNG_MED, 2'b01, 2'b00, 0);
    st(250, `RNG_MED, 2'b01, 2'b00, 0);
    wr(`OFS_ACK, 32'h1);
    st(250, `RNG_MED, 2'b00, 2'b01, 0);
    st(100, `RNG_MED, 2'b10, 2'b11, 0);
    st(250, `RNG_MED, 2'b00, 2'b01, 0);
    st(400, `RNG_MED, 2'b01, 2'b00, 0);
    wr(`OFS_ALARM1, 32'h000F012C);
    st(400, `RNG_MED, 2'b00, 2'b01, 0);
    st(250, `RNG_MED, 2'b00, 2'b01, 0);
    wr(`OFS_ALARM1, 32'h000D012C);
    st(250, `RNG_MED, 2'b00, 2'b01, 0);
    st(400, `RNG_MED, 2'b01, 2'b00, 0);
    target <= 250;
    wr(`OFS_ALARM1, 32'h0005012C);
    wr(`OFS_ALARM1, 32'h000D012C);
    st(250, `RNG_MED, 2'b00, 2'b01, 0);
    finish_test;
  end
endmodule // testbench
`default_nettype wire
